// [bench/cgot_regs_tb.sv]
// Self-checking bench for the gain and offset trim register bank.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               mclk, nrst, rd, wr, neg, ferr, oob, wreq;
    logic [5:0]         adr;
    logic [31:0]        wd, rdata, rdv;
    logic [1:0]         resp, rsp;
    logic [8:0]         gcode;
    logic [7:0]         mag;
    logic [9:0]         span;
    logic signed [16:0] ofs;
    int                 n_mismatch, total_checks, cyc;
    logic [8:0]         gc [5] = '{9'h100, 9'h000, 9'h0c0, 9'h1c0, 9'h1ff};
    logic [8:0]         oc [4] = '{9'h1fe, 9'h1ff, 9'h003, 9'h000};

    cgot_regs DUT (.mclk(mclk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_response(resp), .avs_waitrequest(wreq), .gain_trim_code(gcode),
        .offset_magnitude(mag), .offset_negative(neg), .fs_span_mv(span),
        .offset_uv(ofs), .fixed_bits_err(ferr), .gain_out_of_band(oob));

    // Free-running clock and a cycle budget that cuts a hang short.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon-MM cycle, held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge mclk); while (wreq !== 1'b0);
        rdv = rdata;
        rsp = resp;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic gchk(input logic [8:0] c);
        logic [9:0] e;
        e = 10'(560 + c * 280 / 511);
        for (int i = 0; i < 8 && span !== e; i++) @(posedge mclk);
        chk(32'(gcode), 32'(c));
        chk(32'(span), 32'(e));
    endtask

    task automatic ochk(input logic [7:0] m, input logic n);
        logic signed [16:0] e;
        e = 17'(m * 45048 / 255);
        if (n) e = 17'h0 - e;
        for (int i = 0; i < 8 && ofs !== e; i++) @(posedge mclk);
        chk(32'({m, n}), 32'({mag, neg}));
        chk(32'(ofs), 32'(e));
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Reset, then gain codes, offset codes and a read of an unmapped word.
    initial begin
        nrst = 1'b0; rd = 1'b0; wr = 1'b0; adr = 6'h00; wd = 32'h0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        gchk(9'h100);
        ochk(8'h00, 1'b0);
        $display("reset values done");
        foreach (gc[i]) begin
            bus(1'b1, 6'h0c, {16'h0, gc[i], 7'h7f});
            gchk(gc[i]);
            chk(32'(ferr), 32'h0);
            chk(32'(oob), 32'(gc[i] < 9'h0c0 || gc[i] > 9'h1c0));
        end
        $display("gain trim done");
        foreach (oc[i]) begin
            bus(1'b1, 6'h28, {16'h0, oc[i], 7'h7f});
            ochk(oc[i][8:1], oc[i][0]);
        end
        $display("offset trim done");
        bus(1'b0, 6'h04, 32'h0);
        chk(32'(rsp), 32'(cgot_pkg::RESP_DECERR));
        chk(32'(gcode), 32'h1ff);
        $display("unmapped read done");
        bus(1'b0, 6'h0c, 32'h0);
        chk(rdv, 32'h0);
        chk(32'(rsp), 32'(cgot_pkg::RESP_OKAY));
        bus(1'b1, 6'h0c, {16'h0, 9'h0c0, 7'h00});
        gchk(9'h0c0);
        chk(32'(ferr), 32'h1);
        bus(1'b0, 6'h3c, 32'h0);
        chk(rdv, 32'h1);
        bus(1'b1, 6'h3c, 32'h1);
        bus(1'b0, 6'h3c, 32'h0);
        chk(rdv, 32'h0);
        chk(32'(ferr), 32'h0);
        $display("fixed bits flag done");
        tally_and_finish();
    end
endmodule

// [pkg/cgot_pkg.sv]
// Constants, types and helper functions for the channel gain and offset trim registers.
package cgot_pkg;

    // Bus geometry: byte addresses, one 32-bit word per register.
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [3:0] IDX_GAIN = 4'h3;
    localparam logic [3:0] IDX_OFS  = 4'ha;
    localparam logic [3:0] IDX_STAT = 4'hf;

    // Field positions inside the 16-bit trim words.
    localparam int unsigned GAIN_MSB = 15;
    localparam int unsigned GAIN_LSB = 7;
    localparam int unsigned MAG_MSB  = 15;
    localparam int unsigned MAG_LSB  = 8;
    localparam int unsigned SIGN_BIT = 7;
    localparam int unsigned FIX_MSB  = 6;

    // Status bit positions.
    localparam int unsigned ST_FIX_ERR  = 0;
    localparam int unsigned ST_OUT_BAND = 1;

    // Reset values and fixed patterns.
    localparam logic [8:0] GAIN_RST   = 9'h100;
    localparam logic [7:0] MAG_RST    = 8'h00;
    localparam logic       SIGN_RST   = 1'b0;
    localparam logic [6:0] FIXED_ONES = 7'h7f;

    // Recommended trim band for best performance.
    localparam logic [8:0] GAIN_REC_LO = 9'h0c0;
    localparam logic [8:0] GAIN_REC_HI = 9'h1c0;

    // Full-scale span end points in millivolts and the trim code range.
    localparam logic [9:0] SPAN_MIN_MV = 10'h230;
    localparam logic [9:0] SPAN_NOM_MV = 10'h2bc;
    localparam logic [9:0] SPAN_MAX_MV = 10'h348;
    localparam logic [8:0] GAIN_CODE_MAX = 9'h1ff;

    // Offset full-scale in microvolts at magnitude code ff.
    localparam logic [15:0] OFS_FS_UV   = 16'haff8;
    localparam logic [7:0]  MAG_CODE_MAX = 8'hff;

    // Avalon-MM response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Slave handshake states.
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } cgot_bus_st_t;

    // Byte address of a register index.
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [3:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    // Linear span from a 9-bit code, 560 mV at zero up to 840 mV at all ones.
    function automatic logic [9:0] span_mv(input logic [8:0] code);
        logic [17:0] prod;
        prod    = 18'(code) * 18'(SPAN_MAX_MV - SPAN_MIN_MV);
        span_mv = SPAN_MIN_MV + 10'(prod / 18'(GAIN_CODE_MAX));
    endfunction

    // Signed offset in microvolts from magnitude and direction.
    function automatic logic signed [16:0] offset_uv(input logic [7:0] mag,
                                                       input logic       neg);
        logic [23:0] prod;
        logic [16:0] mag_uv;
        prod      = 24'(mag) * 24'(OFS_FS_UV);
        mag_uv    = 17'(prod / 24'(MAG_CODE_MAX));
        offset_uv = neg ? 17'(17'h0 - mag_uv) : mag_uv;
    endfunction

endpackage

// [pkg/cgot_trim_if.sv]
// Carrier for the stored trim fields between the register bank and the mapping stages.
interface cgot_trim_if;
    logic [8:0] gain_code;
    logic [7:0] ofs_mag;
    logic       ofs_neg;

    modport src (output gain_code, output ofs_mag, output ofs_neg);
    modport dst (input gain_code, input ofs_mag, input ofs_neg);
endinterface

// [verilog/cgot_gain_map.sv]
// Maps the stored gain trim code onto the channel full-scale span.
module cgot_gain_map (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    cgot_trim_if.dst        trim,
    output logic [9:0]      span_mv_q
);

    // [R01] [R04] Linear span.
    // The span follows the code on the next edge, with no recalibration step.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            span_mv_q <= cgot_pkg::SPAN_NOM_MV;
        end else begin
            span_mv_q <= cgot_pkg::span_mv(trim.gain_code);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_SPAN_LINEAR: assert property ( // [R01]
        ##1 span_mv_q == cgot_pkg::span_mv($past(trim.gain_code)))
        else $error("span does not follow the trim code");

    AST_SPAN_ENDS: assert property ( // [R02]
        (trim.gain_code == 9'h000 |=> span_mv_q == cgot_pkg::SPAN_MIN_MV) and
        (trim.gain_code == 9'h1ff |=> span_mv_q == cgot_pkg::SPAN_MAX_MV) and
        (trim.gain_code == 9'h100 |=> span_mv_q == cgot_pkg::SPAN_NOM_MV))
        else $error("span end points wrong");

    AST_NO_RECAL: assert property ( // [R04]
        $changed(trim.gain_code) && cgot_pkg::span_mv(trim.gain_code) != span_mv_q
            |=> $changed(span_mv_q))
        else $error("gain change not applied at once");

endmodule

// [verilog/cgot_offset_map.sv]
// Maps the stored offset magnitude and sign onto a signed offset in microvolts.
module cgot_offset_map (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    cgot_trim_if.dst          trim,
    output logic signed [16:0] offset_uv_q
);

    // [R07] Monotonic signed offset.
    // The offset grows with the magnitude and takes its direction from the sign bit.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            offset_uv_q <= 17'sh0;
        end else begin
            offset_uv_q <= cgot_pkg::offset_uv(trim.ofs_mag, trim.ofs_neg);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_OFS_ENDS: assert property ( // [R08]
        (trim.ofs_mag == 8'h00 |=> offset_uv_q == 17'sh0) and
        (trim.ofs_mag == 8'hff && !trim.ofs_neg |=> offset_uv_q == 17'shaff8))
        else $error("offset end points wrong");

    AST_OFS_DIRECTION: assert property ( // [R09]
        trim.ofs_mag != 8'h00 |=> (offset_uv_q < 0) == $past(trim.ofs_neg))
        else $error("offset direction does not follow the sign bit");

endmodule

// [verilog/cgot_regs.sv]
// Gain and offset trim register bank with its Avalon-MM slave and mapping stages.

// Overview of operation
// [R01] Gain register bits 15 to 7 form a 9-bit code scaling span plus or minus 20%.
// [R02] Code zero gives 560 mV, mid-scale 700 mV, all ones 840 mV.
// [R03] Host should keep the gain code between 0c0 and 1c0 for best performance.
// [R04] A new gain code takes effect at once, with no recalibration.
// [R05] After reset the gain code sits at mid-scale, no adjustment.
// [R06] Host writes bits 6 to 0 of both registers as ones.
// [R07] Offset register bits 15 to 8 are an unsigned magnitude, linear and monotonic.
// [R08] Magnitude 00 gives zero offset, ff about 45 mV.
// [R09] Offset bit 7 clear means positive offset, set means negative.
// [R10] After reset the offset magnitude and sign are both clear.
// [R11] Both trim registers are write-only; reads return no stored value.
module cgot_regs (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic [5:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    input  wire logic [3:0]   avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic [1:0]        avs_response,
    output logic              avs_waitrequest,
    output logic [8:0]        gain_trim_code,
    output logic [7:0]        offset_magnitude,
    output logic              offset_negative,
    output logic [9:0]        fs_span_mv,
    output logic signed [16:0] offset_uv,
    output logic              fixed_bits_err,
    output logic              gain_out_of_band
);

    // Register selected by the bus address; the decode is shared by reads and writes.
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_GAIN = 2'b01,
        SEL_OFS  = 2'b10,
        SEL_STAT = 2'b11
    } cgot_sel_t;

    // Address decode: only exact word addresses hit, anything else answers with an error.
    function automatic cgot_sel_t reg_sel(input logic [5:0] addr);
        if (addr == cgot_pkg::reg_addr(cgot_pkg::IDX_GAIN)) begin
            reg_sel = SEL_GAIN;
        end else if (addr == cgot_pkg::reg_addr(cgot_pkg::IDX_OFS)) begin
            reg_sel = SEL_OFS;
        end else if (addr == cgot_pkg::reg_addr(cgot_pkg::IDX_STAT)) begin
            reg_sel = SEL_STAT;
        end else begin
            reg_sel = SEL_NONE;
        end
    endfunction

    // Flags a gain code outside the band that leaves headroom for the converter's spread.
    function automatic logic out_of_band(input logic [8:0] code);
        out_of_band = (code < cgot_pkg::GAIN_REC_LO) || (code > cgot_pkg::GAIN_REC_HI);
    endfunction

    // Reset synchroniser state and the released copy used everywhere else.
    logic                   rst_meta_q;
    logic                   rst_sync_q;
    logic                   rst_n;

    // Bus handshake state.
    cgot_pkg::cgot_bus_st_t bus_st_q;
    cgot_pkg::cgot_bus_st_t bus_st_d;

    // Decoded request and its qualifiers.
    cgot_sel_t              sel;
    logic                   req;
    logic                   capture;
    logic                   accept;
    logic                   lanes_ok;
    logic                   wr_fire;
    logic                   wr_gain;
    logic                   wr_ofs;
    logic                   wr_stat;

    // Read response registers and the values that they load.
    logic [31:0]            stat_word;
    logic [31:0]            rdata_sel;
    logic [1:0]             resp_sel;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;
    logic [1:0]             resp_q;
    logic [1:0]             resp_d;

    // Stored trim fields.
    logic [8:0]             gain_q;
    logic [8:0]             gain_d;
    logic [7:0]             mag_q;
    logic [7:0]             mag_d;
    logic                   neg_q;
    logic                   neg_d;

    // Status flags and the terms that set and clear them.
    logic                   fix_bad;
    logic                   fix_set;
    logic                   fix_clr;
    logic                   ferr_q;
    logic                   ferr_d;
    logic                   oob_q;
    logic                   oob_d;

    // Carrier for the stored fields towards the mapping stages.
    cgot_trim_if            trim_bus ();

    // Two-flop release of the external reset; assertion of reset stays asynchronous.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Only the second flop is read by the rest of the block.
    assign rst_n = rst_sync_q;

    // Request decode; a request is a read or a write, never both at once.
    assign req      = avs_read || avs_write;
    assign sel      = reg_sel(avs_address);
    assign lanes_ok = avs_byteenable[1] && avs_byteenable[0];
    assign capture  = (bus_st_q == cgot_pkg::BUS_IDLE) && req;
    assign accept   = (bus_st_q == cgot_pkg::BUS_ACK) && req;

    // Waitrequest drops for exactly the cycle in which the request is accepted.
    // Every access therefore costs two cycles: one to look and one to answer.
    assign avs_waitrequest = (bus_st_q != cgot_pkg::BUS_ACK);

    // Handshake sequencing; the answer cycle always returns to idle.
    always_comb begin
        bus_st_d = bus_st_q;
        case (bus_st_q)
            cgot_pkg::BUS_IDLE: begin
                if (req) begin
                    bus_st_d = cgot_pkg::BUS_ACK;
                end
            end
            cgot_pkg::BUS_ACK: begin
                bus_st_d = cgot_pkg::BUS_IDLE;
            end
            default: begin
                bus_st_d = cgot_pkg::BUS_IDLE;
            end
        endcase
    end

    // Handshake state register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_st_q <= cgot_pkg::BUS_IDLE;
        end else begin
            bus_st_q <= bus_st_d;
        end
    end

    // Write strobes fire only at the edge at which waitrequest is seen low.
    // The master holds address and data up to that edge, so they are still valid here.
    assign wr_fire = accept && avs_write;
    assign wr_gain = wr_fire && lanes_ok && (sel == SEL_GAIN);
    assign wr_ofs  = wr_fire && lanes_ok && (sel == SEL_OFS);
    assign wr_stat = wr_fire && avs_byteenable[0] && (sel == SEL_STAT);

    // [R04] Gain applied directly.
    assign gain_d = wr_gain ? avs_writedata[cgot_pkg::GAIN_MSB:cgot_pkg::GAIN_LSB] : gain_q;

    // [R07] [R09] Magnitude and sign.
    assign mag_d = wr_ofs ? avs_writedata[cgot_pkg::MAG_MSB:cgot_pkg::MAG_LSB] : mag_q;
    assign neg_d = wr_ofs ? avs_writedata[cgot_pkg::SIGN_BIT] : neg_q;

    // The fixed low bits are stored nowhere; a wrong pattern only raises a sticky flag.
    // The fields are still taken, so a careless host sees its value applied and flagged.
    assign fix_bad = avs_writedata[cgot_pkg::FIX_MSB:0] != cgot_pkg::FIXED_ONES;
    assign fix_set = (wr_gain || wr_ofs) && fix_bad;
    assign fix_clr = wr_stat && avs_writedata[cgot_pkg::ST_FIX_ERR];

    // A new violation in the same cycle as a clear wins, so no event is lost.
    assign ferr_d = fix_set || (ferr_q && !fix_clr);

    // The band flag follows the code that is stored at this edge.
    assign oob_d = out_of_band(gain_d);

    // [R05] [R10] Trim reset values.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gain_q <= cgot_pkg::GAIN_RST;
            mag_q  <= cgot_pkg::MAG_RST;
            neg_q  <= cgot_pkg::SIGN_RST;
            ferr_q <= 1'b0;
            oob_q  <= 1'b0;
        end else begin
            gain_q <= gain_d;
            mag_q  <= mag_d;
            neg_q  <= neg_d;
            ferr_q <= ferr_d;
            oob_q  <= oob_d;
        end
    end

    // Status word: error flag and band flag at their own bit positions.
    always_comb begin
        stat_word = 32'h0;
        stat_word[cgot_pkg::ST_FIX_ERR]  = ferr_q;
        stat_word[cgot_pkg::ST_OUT_BAND] = oob_q;
    end

    // [R11] No trim read-back.
    assign rdata_sel = (sel == SEL_STAT) ? stat_word : 32'h0;
    assign resp_sel  = (sel == SEL_NONE) ? cgot_pkg::RESP_DECERR : cgot_pkg::RESP_OKAY;

    // The answer loads when the request is first seen and stands through the answer cycle.
    assign rdata_d = capture ? rdata_sel : rdata_q;
    assign resp_d  = capture ? resp_sel : resp_q;

    // Response registers.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0;
            resp_q  <= cgot_pkg::RESP_OKAY;
        end else begin
            rdata_q <= rdata_d;
            resp_q  <= resp_d;
        end
    end

    // Bus outputs come straight from the response registers.
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;

    // Stored fields and status flags towards the pins.
    assign gain_trim_code   = gain_q;
    assign offset_magnitude = mag_q;
    assign offset_negative  = neg_q;
    assign fixed_bits_err   = ferr_q;
    assign gain_out_of_band = oob_q;

    // Stored fields towards the mapping stages.
    assign trim_bus.gain_code = gain_q;
    assign trim_bus.ofs_mag   = mag_q;
    assign trim_bus.ofs_neg   = neg_q;

    // Gain code to full-scale span.
    cgot_gain_map u_gain_map (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .trim      (trim_bus),
        .span_mv_q (fs_span_mv)
    );

    // Offset magnitude and sign to a signed offset.
    cgot_offset_map u_offset_map (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .trim        (trim_bus),
        .offset_uv_q (offset_uv)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Reset leaves the gain at mid-scale and inside the band.
    AST_GAIN_RESET: assert property ( // [R05]
        $rose(rst_n) |-> gain_q == cgot_pkg::GAIN_RST && !oob_q)
        else $error("gain code not at mid-scale after reset");

    // Reset leaves no offset correction.
    AST_OFS_RESET: assert property ( // [R10]
        $rose(rst_n) |-> mag_q == cgot_pkg::MAG_RST && neg_q == cgot_pkg::SIGN_RST)
        else $error("offset fields not clear after reset");

    // The gain code moves only on an accepted write.
    AST_GAIN_HOLD: assert property ( // [R05]
        !wr_gain |=> $stable(gain_q))
        else $error("gain code changed without a write");

    // A read of a trim register never returns its contents.
    AST_WRITE_ONLY: assert property ( // [R11]
        capture && avs_read && sel != SEL_STAT |=> avs_readdata == 32'h0)
        else $error("trim register value read back");

    // Main scenarios that the tests are meant to reach.
    COV_GAIN_WRITE: cover property (wr_gain);

    COV_OFS_NEG: cover property (wr_ofs && avs_writedata[cgot_pkg::SIGN_BIT]);

    COV_FIX_ERR: cover property (fix_set);

    COV_DECERR: cover property (!avs_waitrequest && avs_response == cgot_pkg::RESP_DECERR);

endmodule
